// >>> sim/flash_status_write_protect_tb_top.sv
// Self-checking bench for the status and write-protect block
`default_nettype none
module flash_status_write_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys, rst, wp_pin_n, hold_pin_n;
  wire logic  cmd_valid, op_done, status_rd_valid, op_start, suspend_req, reset_req;
  wire logic  cmd_accepted, cmd_dropped, pins_are_data, wp_active_n, hold_active_n;
  wire logic [7:0] cmd_opcode, cmd_wdata, status_byte;
  wire logic [5:0] cmd_block;
  wire logic [2:0] op_class;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] wr_ops [16] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7,
                              8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
  logic [7:0] vol_ops [3] = '{8'hC0, 8'h63, 8'h83};
  fsw_host_model fsw_host_model_i (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_block(cmd_block), .cmd_wdata(cmd_wdata), .op_done(op_done));
  fsw_status_core fsw_status_core_i (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_block(cmd_block), .cmd_wdata(cmd_wdata), .op_done(op_done),
    .wp_pin_n(wp_pin_n), .hold_pin_n(hold_pin_n), .status_byte(status_byte),
    .status_rd_valid(status_rd_valid), .op_start(op_start), .op_class(op_class),
    .suspend_req(suspend_req), .reset_req(reset_req), .cmd_accepted(cmd_accepted),
    .cmd_dropped(cmd_dropped), .pins_are_data(pins_are_data), .wp_active_n(wp_active_n),
    .hold_active_n(hold_active_n));
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic cmd(input logic [7:0] op, input logic [5:0] blk, input logic [7:0] wd,
                     input logic acc);
    fsw_host_model_i.send(op, blk, wd);
    #1;
    chk1("accepted", acc, cmd_accepted);
    chk1("dropped", !acc, cmd_dropped);
  endtask
  task automatic done(input int n);
    fsw_host_model_i.finish(n);
    #1;
  endtask
  // Pin changes need four edges through the synchroniser, six are allowed
  task automatic pin_wait(input logic lvl, input logic hold_lvl);
    @(posedge clk_sys);
    wp_pin_n <= lvl;
    hold_pin_n <= hold_lvl;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic s_program;
    cmd(8'h06, 6'h00, 8'h00, 1'b1);
    chk8("status", 8'h02, status_byte);
    cmd(8'h02, 6'h00, 8'h00, 1'b1);
    chk1("start", 1'b1, op_start);
    chk8("class", 8'h01, {5'h00, op_class});
    chk8("status", 8'h03, status_byte);
    cmd(8'h05, 6'h00, 8'h00, 1'b1);
    chk1("read", 1'b1, status_rd_valid);
    cmd(8'h06, 6'h00, 8'h00, 1'b0);
    cmd(8'h66, 6'h00, 8'h00, 1'b1);
    chk1("reset request", 1'b1, reset_req);
    done(7);
    chk8("status", 8'h00, status_byte);
    chk8("class", 8'h00, {5'h00, op_class});
  endtask
  task automatic s_filters;
    foreach (wr_ops[i]) cmd(wr_ops[i], 6'h00, 8'hFC, 1'b0);
    chk8("status", 8'h00, status_byte);
    foreach (vol_ops[i]) cmd(vol_ops[i], 6'h00, 8'h00, 1'b1);
    chk8("status", 8'h00, status_byte);
    cmd(8'h06, 6'h00, 8'h00, 1'b1);
    cmd(8'h04, 6'h00, 8'h00, 1'b1);
    chk8("status", 8'h00, status_byte);
    cmd(8'h06, 6'h00, 8'h00, 1'b1);
    cmd(8'h60, 6'h00, 8'h00, 1'b1);
    chk8("class", 8'h03, {5'h00, op_class});
    cmd(8'h75, 6'h00, 8'h00, 1'b1);
    done(1);
    pin_wait(1'b0, 1'b0);
    chk1("protect pin", 1'b0, wp_active_n);
    chk1("hold pin", 1'b0, hold_active_n);
    pin_wait(1'b1, 1'b1);
  endtask
  // Set a protect code, then one block that must refuse and one that must run
  task automatic s_protect(input logic [7:0] code, input logic [5:0] bad, input logic [5:0] ok);
    cmd(8'h06, 6'h00, 8'h00, 1'b1);
    cmd(8'h01, 6'h00, code, 1'b1);
    chk8("status", code | 8'h03, status_byte);
    cmd(8'h75, 6'h00, 8'h00, 1'b0);
    done(1);
    cmd(8'h06, 6'h00, 8'h00, 1'b1);
    cmd(8'hD8, bad, 8'h00, 1'b0);
    cmd(8'hC7, 6'h00, 8'h00, 1'b0);
    chk8("status", code | 8'h02, status_byte);
    cmd(8'h20, ok, 8'h00, 1'b1);
    done(2);
  endtask
  task automatic s_lock;
    cmd(8'h06, 6'h00, 8'h00, 1'b1);
    cmd(8'h01, 6'h00, 8'h80, 1'b1);
    done(1);
    pin_wait(1'b0, 1'b1);
    cmd(8'h06, 6'h00, 8'h00, 1'b1);
    cmd(8'h01, 6'h00, 8'h00, 1'b0);
    chk8("status", 8'h82, status_byte);
    pin_wait(1'b1, 1'b1);
    cmd(8'h01, 6'h00, 8'h40, 1'b1);
    done(1);
    pin_wait(1'b0, 1'b0);
    chk1("quad", 1'b1, pins_are_data);
    chk1("protect pin", 1'b1, wp_active_n);
    chk1("hold pin", 1'b1, hold_active_n);
    cmd(8'h06, 6'h00, 8'h00, 1'b1);
    cmd(8'hD8, 6'h05, 8'h00, 1'b1);
    cmd(8'h75, 6'h00, 8'h00, 1'b1);
    chk1("suspend", 1'b1, suspend_req);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk8("status", 8'h40, status_byte);
    cmd(8'h05, 6'h00, 8'h00, 1'b1);
    chk8("status", 8'h40, status_byte);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    complete_run();
  end
  initial
  begin
    rst = 1'b1;
    wp_pin_n = 1'b1;
    hold_pin_n = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk8("status", 8'h00, status_byte);
    s_program();
    s_filters();
    s_protect(8'h04, 6'h3F, 6'h3E);
    s_protect(8'h38, 6'h00, 6'h01);
    s_protect(8'h14, 6'h30, 6'h2F);
    s_lock();
    complete_run();
  end
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
endmodule
`default_nettype wire

// >>> sim/fsw_host_model.sv
// Host command source with a stand-in array engine completion
`default_nettype none
module fsw_host_model (
  // Clock
  input  wire logic       clk_sys,
  // Command and completion
  output var  logic       cmd_valid,
  output var  logic [7:0] cmd_opcode,
  output var  logic [5:0] cmd_block,
  output var  logic [7:0] cmd_wdata,
  output var  logic       op_done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_block = 6'h00;
    cmd_wdata = 8'h00;
    op_done = 1'b0;
  end
  task automatic send(input logic [7:0] op, input logic [5:0] blk, input logic [7:0] wd);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_block <= blk;
    cmd_wdata <= wd;
    @(posedge clk_sys);
    // Released lines show the inverse so a stale value cannot pass
    cmd_valid <= 1'b0;
    cmd_opcode <= ~op;
    cmd_block <= ~blk;
    cmd_wdata <= ~wd;
  endtask
  // Engine answers after n cycles: 1 is prompt, larger is slow
  task automatic finish(input int n);
    repeat (n) @(posedge clk_sys);
    op_done <= 1'b1;
    @(posedge clk_sys);
    op_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/fsw_status_core_assertions.sv
// Port-level checks for the status and write-protect block
`default_nettype none
module fsw_status_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Command and completion
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic       op_done,
  // Results
  input wire logic [7:0] status_byte,
  input wire logic       status_rd_valid,
  input wire logic       op_start,
  input wire logic       cmd_accepted,
  input wire logic       cmd_dropped,
  input wire logic       pins_are_data,
  input wire logic       wp_active_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  one_answer_a: assert property (cmd_valid |=> cmd_accepted ^ cmd_dropped)
    else $error("command not answered exactly once");
  // Any command may be a suspend or reset, so only quiet cycles must keep busy
  busy_hold_a: assert property (
    status_byte[0] && !op_done && !cmd_valid |=> status_byte[0])
    else $error("busy fell without completion");
  busy_launch_a: assert property ($rose(status_byte[0]) |-> op_start)
    else $error("busy rose without a launch");
  done_clear_a: assert property (
    op_done && status_byte[0] |=> status_byte[1:0] == 2'h0)
    else $error("completion left busy or latch set");
  write_enable_cmd_set_a: assert property (
    cmd_valid && cmd_opcode == 8'h06 && !status_byte[0] |=> status_byte[1])
    else $error("write enable did not set the latch");
  no_latch_a: assert property (
    cmd_valid && cmd_opcode == 8'h02 && status_byte[1:0] == 2'h0
    |=> cmd_dropped && !op_start && status_byte == $past(status_byte))
    else $error("program ran without the latch");
  chip_bp_a: assert property (
    cmd_valid && cmd_opcode == 8'hC7 && status_byte[5:2] != 4'h0 |=> cmd_dropped)
    else $error("chip erase taken with protection set");
  rd_busy_a: assert property (cmd_valid && cmd_opcode == 8'h05 |=> status_rd_valid)
    else $error("status read refused");
  latch_keep_a: assert property (
    cmd_valid && cmd_opcode == 8'h01 && !status_byte[0]
    |=> status_byte[1] == $past(status_byte[1]))
    else $error("status write moved the latch");
  quad_pins_a: assert property (pins_are_data |-> wp_active_n)
    else $error("protect pin active in quad mode");
  cover property (op_start);
  cover property (cmd_dropped && status_byte[0]);
  cover property (status_rd_valid && status_byte[0]);
endmodule
bind fsw_status_core fsw_status_chk fsw_status_chk_i (.clk_sys(clk_sys), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .op_done(op_done),
  .status_byte(status_byte), .status_rd_valid(status_rd_valid), .op_start(op_start),
  .cmd_accepted(cmd_accepted), .cmd_dropped(cmd_dropped),
  .pins_are_data(pins_are_data), .wp_active_n(wp_active_n));
`default_nettype wire

// >>> verilog/fsw_consts.vh
// Constants for the flash status and write-protect block
`ifndef FSW_CONSTS_VH
`define FSW_CONSTS_VH
// Status byte bit positions
`define FSW_BIT_BUSY      0
`define FSW_BIT_LATCH     1
`define FSW_BIT_BP_LO     2
`define FSW_BIT_BP_HI     5
`define FSW_BIT_QUAD      6
`define FSW_BIT_SWD       7
`define FSW_STATUS_RESET  8'h00
`define FSW_NV_DEFAULT    6'h00
// Command opcodes
`define FSW_OP_WR_EN      8'h06
`define FSW_OP_WR_DIS     8'h04
`define FSW_OP_STAT_WR    8'h01
`define FSW_OP_STAT_RD    8'h05
`define FSW_OP_RDFR       8'h48
`define FSW_OP_RDERP      8'h81
`define FSW_OP_PROG       8'h02
`define FSW_OP_QPROG_A    8'h32
`define FSW_OP_QPROG_B    8'h38
`define FSW_OP_SE_A       8'hD7
`define FSW_OP_SE_B       8'h20
`define FSW_OP_BE32       8'h52
`define FSW_OP_BE64       8'hD8
`define FSW_OP_CE_A       8'hC7
`define FSW_OP_CE_B       8'h60
`define FSW_OP_WRFN       8'h42
`define FSW_OP_NVRP       8'h65
`define FSW_OP_NVERP      8'h85
`define FSW_OP_IRE        8'h64
`define FSW_OP_IRPG       8'h62
`define FSW_OP_ABW        8'h15
`define FSW_OP_VRP_A      8'hC0
`define FSW_OP_VRP_B      8'h63
`define FSW_OP_VERP       8'h83
`define FSW_OP_SUSP       8'h75
`define FSW_OP_RSTEN      8'h66
`define FSW_OP_RST        8'h99
// Operation classes reported to the array engine
`define FSW_OPC_NONE      3'h0
`define FSW_OPC_PROG      3'h1
`define FSW_OPC_ERASE     3'h2
`define FSW_OPC_CHIP      3'h3
`define FSW_OPC_NVREG     3'h4
`define FSW_OPC_STATUS    3'h5
`endif

// >>> verilog/fsw_protect_decode.v
// Block-protect decode: tells whether a 64 KB block lies in the protected region
`default_nettype none
module fsw_protect_decode #(
  parameter BLK_BITS = 6
) (
  // Protect code and block under test
  input  wire [3:0]          bp_code,
  input  wire [BLK_BITS-1:0] block_idx,
  // Result
  output reg                 is_protected
);
  localparam [BLK_BITS:0] BLK_COUNT = {1'b1, {BLK_BITS{1'b0}}};
  reg [BLK_BITS:0] span;
  always @*
  begin
    span = {(BLK_BITS+1){1'b0}};
    is_protected = 1'b0;
    if (bp_code[3] == 1'b0)
    begin
      // Top-down region; 0111 covers every block
      if (bp_code[2:0] == 3'h7)
        is_protected = 1'b1;
      else if (bp_code[2:0] != 3'h0)
      begin
        span = {{BLK_BITS{1'b0}}, 1'b1} << (bp_code[2:0] - 3'h1);
        is_protected = ({1'b0, block_idx} >= (BLK_COUNT - span));
      end
    end
    else
    begin
      // Bottom-up region; 1000 covers every block, 1111 none
      if (bp_code[2:0] == 3'h0)
        is_protected = 1'b1;
      else if (bp_code[2:0] != 3'h7)
      begin
        span = {{BLK_BITS{1'b0}}, 1'b1} << (3'h6 - bp_code[2:0]);
        is_protected = ({1'b0, block_idx} < span);
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/fsw_status_core.v
// Status byte, write-enable latch, busy filter and hardware write protection
// Functional notes
// - Status bit 0 reads 1 while program, erase or register write runs.
// - While busy, only status/function/ext-read reads and resets are accepted.
// - During program or erase, suspend is also accepted.
// - Busy clears when the operation ends, success or not.
// - Write-enable command sets the latch in status bit 1.
// - Write-disable clears the latch; completion of any write clears it.
// - Only write-enable sets the latch; status write cannot.
// - Program and erase commands need the latch set, else inhibited.
// - Register writes, info-row and autoboot writes need the latch set.
// - Volatile read-parameter set commands need no latch.
// - Block-protect bits 2..5 select a region; program or erase there inhibited.
// - Chip erase ignored unless all block-protect bits are zero.
// - Write-disable 1 with protect pin low locks bits; status writes ignored.
// - Status write permitted when write-disable 0, or pin high.
// - Quad-enable 0: shared pins are protect and hold; 1: data lines (code still applies the protect-pin status-write lock).
// - Protect, quad-enable and write-disable bits are non-volatile, default 0.
// - Full status byte returned on status read, even while busy.
// - Protect code decodes 64 KB blocks, top-down or bottom-up.
`default_nettype none
`include "fsw_consts.vh"
module fsw_status_core #(
  parameter BLK_BITS = 6
) (
  // Clock and reset
  input  wire                clk_sys,
  input  wire                rst,
  // Decoded command from the serial front end
  input  wire                cmd_valid,
  input  wire [7:0]          cmd_opcode,
  input  wire [BLK_BITS-1:0] cmd_block,
  input  wire [7:0]          cmd_wdata,
  // Array engine completion
  input  wire                op_done,
  // Shared pins
  input  wire                wp_pin_n,
  input  wire                hold_pin_n,
  // Status byte and command results
  output reg  [7:0]          status_byte,
  output reg                 status_rd_valid,
  output reg                 op_start,
  output reg  [2:0]          op_class,
  output reg                 suspend_req,
  output reg                 reset_req,
  output reg                 cmd_accepted,
  output reg                 cmd_dropped,
  // Pin function selection
  output reg                 pins_are_data,
  output reg                 wp_active_n,
  output reg                 hold_active_n
);
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  // Non-volatile cells live outside the reset; they start at factory default
  reg [5:0] nv_bits = `FSW_NV_DEFAULT;
  reg       busy_flag;
  reg       write_enable_latch;
  reg [1:0] state;
  reg [2:0] run_class;
  reg       wp_s1;
  reg       wp_s2;
  reg       wp_s3;
  reg       wp_level;
  reg       hold_s1;
  reg       hold_s2;
  reg       hold_s3;
  reg       hold_level;
  reg       next_busy;
  reg       next_latch;
  reg [5:0] next_nv;
  reg [2:0] next_class;
  reg       next_start;
  reg       next_accept;
  reg       next_drop;
  reg       next_susp;
  reg       next_rst_req;
  reg       next_rd;
  wire      blk_protected;
  wire [3:0] bp_code;
  wire      quad_enable;
  wire      status_write_disable;

  assign bp_code = nv_bits[3:0];
  assign quad_enable = nv_bits[4];
  assign status_write_disable = nv_bits[5];

  fsw_protect_decode #(
    .BLK_BITS (BLK_BITS)
  ) u_decode (
    .bp_code      (bp_code),
    .block_idx    (cmd_block),
    .is_protected (blk_protected)
  );

  // Command classifier, shared by the busy filter and dispatch
  function [2:0] fsw_class;
    input [7:0] op;
    begin
      case (op)
        `FSW_OP_PROG, `FSW_OP_QPROG_A, `FSW_OP_QPROG_B:
          fsw_class = `FSW_OPC_PROG;
        `FSW_OP_SE_A, `FSW_OP_SE_B, `FSW_OP_BE32, `FSW_OP_BE64:
          fsw_class = `FSW_OPC_ERASE;
        `FSW_OP_CE_A, `FSW_OP_CE_B:
          fsw_class = `FSW_OPC_CHIP;
        `FSW_OP_WRFN, `FSW_OP_NVRP, `FSW_OP_NVERP, `FSW_OP_IRE, `FSW_OP_IRPG,
        `FSW_OP_ABW:
          fsw_class = `FSW_OPC_NVREG;
        `FSW_OP_STAT_WR:
          fsw_class = `FSW_OPC_STATUS;
        default:
          fsw_class = `FSW_OPC_NONE;
      endcase
    end
  endfunction

  function is_busy_ok;
    input [7:0] op;
    input [2:0] running;
    begin
      case (op)
        `FSW_OP_STAT_RD, `FSW_OP_RDFR, `FSW_OP_RDERP, `FSW_OP_RSTEN, `FSW_OP_RST:
          is_busy_ok = 1'b1;
        `FSW_OP_SUSP:
          is_busy_ok = (running == `FSW_OPC_PROG) || (running == `FSW_OPC_ERASE)
                       || (running == `FSW_OPC_CHIP);
        default:
          is_busy_ok = 1'b0;
      endcase
    end
  endfunction

  // Three-stage pin synchronisers; level moves only when stages two and three agree
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      wp_s3 <= 1'b1;
      wp_level <= 1'b1;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
      hold_s3 <= 1'b1;
      hold_level <= 1'b1;
    end
    else
    begin
      wp_s1 <= wp_pin_n;
      wp_s2 <= wp_s1;
      wp_s3 <= wp_s2;
      hold_s1 <= hold_pin_n;
      hold_s2 <= hold_s1;
      hold_s3 <= hold_s2;
      if (wp_s2 == wp_s3)
        wp_level <= wp_s3;
      if (hold_s2 == hold_s3)
        hold_level <= hold_s3;
    end
  end

  always @*
  begin
    next_busy = busy_flag;
    next_latch = write_enable_latch;
    next_nv = nv_bits;
    next_class = run_class;
    next_start = 1'b0;
    next_accept = 1'b0;
    next_drop = 1'b0;
    next_susp = 1'b0;
    next_rst_req = 1'b0;
    next_rd = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          next_accept = 1'b1;
          case (cmd_opcode)
            `FSW_OP_WR_EN:
              next_latch = 1'b1;
            `FSW_OP_WR_DIS:
              next_latch = 1'b0;
            `FSW_OP_STAT_RD:
              next_rd = 1'b1;
            `FSW_OP_RSTEN, `FSW_OP_RST:
              next_rst_req = 1'b1;
            `FSW_OP_VRP_A, `FSW_OP_VRP_B, `FSW_OP_VERP:
              next_accept = 1'b1;
            default:
            begin
              if (fsw_class(cmd_opcode) != `FSW_OPC_NONE)
              begin
                if (!write_enable_latch)
                begin
                  next_accept = 1'b0;
                  next_drop = 1'b1;
                end
                else if (fsw_class(cmd_opcode) == `FSW_OPC_CHIP && bp_code != 4'h0)
                begin
                  next_accept = 1'b0;
                  next_drop = 1'b1;
                end
                else if ((fsw_class(cmd_opcode) == `FSW_OPC_PROG ||
                          fsw_class(cmd_opcode) == `FSW_OPC_ERASE) && blk_protected)
                begin
                  next_accept = 1'b0;
                  next_drop = 1'b1;
                end
                else if (fsw_class(cmd_opcode) == `FSW_OPC_STATUS &&
                         status_write_disable && !wp_level)
                begin
                  next_accept = 1'b0;
                  next_drop = 1'b1;
                end
                else
                begin
                  // Latch is left alone here; completion clears it
                  if (fsw_class(cmd_opcode) == `FSW_OPC_STATUS)
                    next_nv = cmd_wdata[7:2];
                  next_busy = 1'b1;
                  next_class = fsw_class(cmd_opcode);
                  next_start = 1'b1;
                end
              end
            end
          endcase
        end
      end
      ST_BUSY:
      begin
        if (cmd_valid)
        begin
          if (is_busy_ok(cmd_opcode, run_class))
          begin
            next_accept = 1'b1;
            next_rd = (cmd_opcode == `FSW_OP_STAT_RD);
            next_susp = (cmd_opcode == `FSW_OP_SUSP);
            next_rst_req = (cmd_opcode == `FSW_OP_RSTEN) || (cmd_opcode == `FSW_OP_RST);
          end
          else
            next_drop = 1'b1;
        end
        if (op_done)
        begin
          next_busy = 1'b0;
          next_latch = 1'b0;
          next_class = `FSW_OPC_NONE;
        end
      end
      default:
      begin
        next_busy = 1'b0;
        next_class = `FSW_OPC_NONE;
      end
    endcase
  end

  always @(posedge clk_sys)
  begin
    // Non-volatile cells ride through reset; a command seen during reset must not reach them
    if (rst)
    begin
      state <= ST_IDLE;
      busy_flag <= 1'b0;
      write_enable_latch <= 1'b0;
      run_class <= `FSW_OPC_NONE;
      status_byte <= `FSW_STATUS_RESET | {nv_bits, 2'b00};
      status_rd_valid <= 1'b0;
      op_start <= 1'b0;
      op_class <= `FSW_OPC_NONE;
      suspend_req <= 1'b0;
      reset_req <= 1'b0;
      cmd_accepted <= 1'b0;
      cmd_dropped <= 1'b0;
      pins_are_data <= 1'b0;
      wp_active_n <= 1'b1;
      hold_active_n <= 1'b1;
    end
    else
    begin
      state <= next_busy ? ST_BUSY : ST_IDLE;
      busy_flag <= next_busy;
      nv_bits <= next_nv;
      write_enable_latch <= next_latch;
      run_class <= next_class;
      status_byte <= {next_nv, next_latch, next_busy};
      status_rd_valid <= next_rd;
      op_start <= next_start;
      op_class <= next_class;
      suspend_req <= next_susp;
      reset_req <= next_rst_req;
      cmd_accepted <= next_accept;
      cmd_dropped <= next_drop;
      // Protect/hold outputs follow the shared pins only while quad mode is off; the status-write lock reads the protect pin in either mode
      pins_are_data <= next_nv[4];
      wp_active_n <= next_nv[4] ? 1'b1 : wp_level;
      hold_active_n <= next_nv[4] ? 1'b1 : hold_level;
    end
  end
endmodule
`default_nettype wire
